// ===== rtl/phu_pkg.sv
package phu_pkg;

   // Link clock choices, in hertz
   localparam int unsigned PHU_CLK_5M = 5_000_000;
   localparam int unsigned PHU_CLK_10M = 10_000_000;
   localparam int unsigned PHU_CLK_20M = 20_000_000;
   localparam int unsigned PHU_CLK_40M = 40_000_000;
   localparam int unsigned PHU_SYS_CLK_HZ = PHU_CLK_20M;
   localparam int unsigned PHU_CLK_DIV = 2;

   // Reset timing
   localparam int unsigned PHU_RST_PULSE_CYC = 256;
   localparam int unsigned PHU_STAB_TIME_US = 5000;
   localparam int unsigned PHU_STAB_CYC =
      PHU_STAB_TIME_US * (PHU_SYS_CLK_HZ / 1_000_000);

   // Pin handshake timing, in clk_sys cycles
   localparam int unsigned PHU_SETTLE_CYC = 12;
   localparam int unsigned PHU_GAP_CYC = 4;

   // Data path
   localparam int unsigned PHU_DATA_W = 8;
   localparam int unsigned PHU_FIFO_DEPTH = 16;
   localparam logic [7:0] PHU_NULL_TOKEN = 8'h00;
   localparam logic [7:0] PHU_BUS_IDLE = 8'hff;
   localparam logic [7:0] PHU_ZERO_BYTE = 8'h00;
   localparam logic [6:0] PHU_HS_PAD = 7'h00;
   localparam int unsigned PHU_HS_BIT = 0;

   // Pin levels
   localparam logic PHU_CS_ON = 1'b0;
   localparam logic PHU_CS_OFF = 1'b1;
   localparam logic PHU_RW_READ = 1'b1;
   localparam logic PHU_RW_WRITE = 1'b0;
   localparam logic PHU_SEL_HS = 1'b1;
   localparam logic PHU_SEL_DATA = 1'b0;

endpackage : phu_pkg

// ===== rtl/phu_link_if.sv
`timescale 1ns/1ns
interface phu_link_if;
   import phu_pkg::*;

   logic handshake_select;
   logic chip_select_n;
   logic read_write;
   logic [7:0] host_data;
   logic host_data_oe;
   logic [7:0] dev_data;
   logic dev_data_oe;
   logic [7:0] data;
   logic attention;
   logic host_reset_oe;
   logic dev_reset_oe;
   logic host_reset_line;

   // Wire resolution of the shared pins
   assign data = host_data_oe ? host_data :
                 (dev_data_oe ? dev_data : PHU_BUS_IDLE);
   assign host_reset_line = ~(host_reset_oe | dev_reset_oe);

   modport host (
      output handshake_select,
      output chip_select_n,
      output read_write,
      output host_data,
      output host_data_oe,
      output host_reset_oe,
      input data,
      input attention,
      input host_reset_line
   );

   modport device (
      input handshake_select,
      input chip_select_n,
      input read_write,
      input data,
      input host_reset_line,
      output dev_data,
      output dev_data_oe,
      output attention,
      output dev_reset_oe
   );

endinterface : phu_link_if

// ===== rtl/phu_fifo.sv
`timescale 1ns/1ns
module phu_fifo
   import phu_pkg::*;
#(
   parameter int unsigned WIDTH = PHU_DATA_W,
   parameter int unsigned DEPTH = PHU_FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] ZERO_CNT = '0;
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;

   assign in_ready = (cnt_reg != FULL_CNT);
   assign out_valid = (cnt_reg != ZERO_CNT);
   assign out_data = mem[rd_ptr_reg];
   assign push = ce & in_valid & in_ready;
   assign pop = ce & out_valid & out_ready;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + 1'b1;
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end

endmodule : phu_fifo

// ===== rtl/phu_device.sv
`timescale 1ns/1ns
module phu_device
   import phu_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   phu_link_if.device link,
   input wire logic up_send,
   input wire logic [7:0] up_len,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic wdog_expire,
   input wire logic soft_reset,
   output logic up_busy,
   output logic token_held
);
   typedef enum logic [2:0] {
      D_IDLE = 3'b001,
      D_SHOW = 3'b010,
      D_STAGE = 3'b100
   } phu_dev_state_t;

   localparam int unsigned NSYNC = 12;
   localparam logic [8:0] RST_LAST = 9'(PHU_RST_PULSE_CYC - 1);

   phu_dev_state_t state_reg;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_reg;
   logic [NSYNC-1:0] s2_reg;
   logic [NSYNC-1:0] s3_reg;
   logic [NSYNC-1:0] pin_reg;
   logic cs_n_s;
   logic a0_s;
   logic rw_s;
   logic rst_line_s;
   logic cs_n_q_reg;
   logic sel_a0_reg;
   logic sel_rw_reg;
   logic tick_reg;
   logic rd_ev_reg;
   logic tok_ev_reg;
   logic pend_reg;
   logic token_reg;
   logic [7:0] len_reg;
   logic [7:0] remain_reg;
   logic [7:0] byte_reg;
   logic byte_ok_reg;
   logic attn_reg;
   logic [7:0] d_reg;
   logic d_oe_reg;
   logic rst_oe_reg;
   logic [8:0] rst_cnt_reg;
   logic up_busy_reg;
   logic token_out_reg;
   logic fifo_valid;
   logic fifo_pop;
   logic [7:0] fifo_data;
   logic cs_rise;
   logic dl_busy;
   logic proto_clr;

   assign pin_raw = {link.host_reset_line, link.read_write,
                     link.handshake_select, link.chip_select_n, link.data};
   assign cs_n_s = pin_reg[8];
   assign a0_s = pin_reg[9];
   assign rw_s = pin_reg[10];
   assign rst_line_s = pin_reg[11];
   assign cs_rise = ~cs_n_q_reg & cs_n_s;
   assign dl_busy = token_reg | (~cs_n_s & (rw_s == PHU_RW_WRITE)); // see RL12
   assign proto_clr = ~rst_line_s;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            s1_reg[i] <= 1'b1;
            s2_reg[i] <= 1'b1;
            s3_reg[i] <= 1'b1;
            pin_reg[i] <= 1'b1;
         end else if (ce) begin
            s1_reg[i] <= pin_raw[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
            if (s2_reg[i] == s3_reg[i]) begin
               pin_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Half rate core tick
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tick_reg <= 1'b0;
      end else if (ce) begin
         tick_reg <= ~tick_reg; // see RL2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Host strobe events, held until the next tick
   always_ff @(posedge clk_sys) begin
      if (!rst_n || (ce && proto_clr)) begin
         cs_n_q_reg <= 1'b1;
         sel_a0_reg <= 1'b0;
         sel_rw_reg <= 1'b1;
         rd_ev_reg <= 1'b0;
         tok_ev_reg <= 1'b0;
      end else if (ce) begin
         cs_n_q_reg <= cs_n_s;
         if (!cs_n_s) begin
            sel_a0_reg <= a0_s;
            sel_rw_reg <= rw_s;
         end
         if (cs_rise && sel_rw_reg && (sel_a0_reg == PHU_SEL_DATA)) begin
            rd_ev_reg <= 1'b1; // see RL8
         end else if (tick_reg) begin
            rd_ev_reg <= 1'b0;
         end
         if (cs_rise && (sel_rw_reg == PHU_RW_WRITE)) begin
            tok_ev_reg <= 1'b1; // see RL6
         end else if (tick_reg) begin
            tok_ev_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write token
   always_ff @(posedge clk_sys) begin
      if (!rst_n || (ce && proto_clr)) begin
         token_reg <= 1'b0;
      end else if (ce && tick_reg) begin
         if (tok_ev_reg) begin
            token_reg <= 1'b1; // see RL6
         end else if (token_reg) begin
            token_reg <= 1'b0; // see RL14
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Uplink message sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n || (ce && proto_clr)) begin
         state_reg <= D_IDLE;
         pend_reg <= 1'b0;
         len_reg <= PHU_ZERO_BYTE;
         remain_reg <= PHU_ZERO_BYTE;
         byte_reg <= PHU_ZERO_BYTE;
         byte_ok_reg <= 1'b0;
      end else if (ce) begin
         if (up_send && !pend_reg && state_reg == D_IDLE) begin
            pend_reg <= 1'b1;
            len_reg <= up_len;
         end
         if (tick_reg) begin
            unique case (state_reg)
               D_IDLE: begin
                  if (pend_reg && !dl_busy) begin
                     byte_reg <= len_reg; // see RL9
                     remain_reg <= len_reg;
                     byte_ok_reg <= 1'b1;
                     state_reg <= D_SHOW;
                  end
               end
               D_SHOW: begin
                  if (rd_ev_reg) begin
                     byte_ok_reg <= 1'b0; // see RL8
                     if (remain_reg == PHU_ZERO_BYTE) begin
                        pend_reg <= 1'b0;
                        state_reg <= D_IDLE;
                     end else begin
                        state_reg <= D_STAGE;
                     end
                  end
               end
               D_STAGE: begin
                  if (fifo_valid) begin
                     byte_reg <= fifo_data;
                     byte_ok_reg <= 1'b1; // see RL8
                     remain_reg <= remain_reg - 1'b1;
                     state_reg <= D_SHOW;
                  end
               end
            endcase
         end
      end
   end

   assign fifo_pop = tick_reg & (state_reg == D_STAGE) & ~proto_clr;

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         attn_reg <= 1'b0;
         d_reg <= PHU_BUS_IDLE;
         d_oe_reg <= 1'b0;
         up_busy_reg <= 1'b0;
         token_out_reg <= 1'b0;
      end else if (ce) begin
         attn_reg <= pend_reg & ~token_reg & ~dl_busy & ~proto_clr; // see RL4 RL11
         d_oe_reg <= ~cs_n_s & (rw_s == PHU_RW_READ) & ~proto_clr;
         d_reg <= (a0_s == PHU_SEL_HS) ? {PHU_HS_PAD, byte_ok_reg} : byte_reg;
         up_busy_reg <= pend_reg;
         token_out_reg <= token_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset pulse on watchdog or software command
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rst_oe_reg <= 1'b0;
         rst_cnt_reg <= '0;
      end else if (ce) begin
         if (!rst_oe_reg && (wdog_expire || soft_reset)) begin
            rst_oe_reg <= 1'b1; // see RL13
            rst_cnt_reg <= RST_LAST;
         end else if (rst_oe_reg) begin
            if (rst_cnt_reg == '0) begin
               rst_oe_reg <= 1'b0;
            end else begin
               rst_cnt_reg <= rst_cnt_reg - 1'b1;
            end
         end
      end
   end

   phu_fifo #(
      .WIDTH(PHU_DATA_W),
      .DEPTH(PHU_FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   assign link.attention = attn_reg;
   assign link.dev_data = d_reg;
   assign link.dev_data_oe = d_oe_reg;
   assign link.dev_reset_oe = rst_oe_reg;
   assign up_busy = up_busy_reg;
   assign token_held = token_out_reg;

endmodule : phu_device

// ===== rtl/phu_host.sv
`timescale 1ns/1ns
// Function
// RL1 - Link clock is 5, 10, 20 or 40 MHz
// RL2 - Device core runs at half input clock
// RL3 - Hold device reset until clock stable
// RL4 - Device raises attention when uplink ready
// RL5 - Select high reads handshake, low reads data
// RL6 - Token passes after message or null token
// RL7 - Poll handshake, reselect data, sample byte
// RL8 - Every byte gets its own handshake poll
// RL9 - Length byte comes before data bytes
// RL10 - Select and data share one bus bridge
// RL11 - No attention while device holds token
// RL12 - No attention during downlink activity
// RL13 - Watchdog or soft reset: 256-cycle low pulse
// RL14 - Device never keeps the token
// RL15 - Read level held through whole uplink
// RL16 - Start uplink only on attention rising edge
module phu_host
   import phu_pkg::*;
#(
   parameter int unsigned STAB_CYC = PHU_STAB_CYC // see RL3
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   phu_link_if.host link,
   input wire logic token_req,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic rx_busy,
   output logic dev_in_reset
);
   typedef enum logic [6:0] {
      H_RST = 7'b0000001,
      H_IDLE = 7'b0000010,
      H_POLL = 7'b0000100,
      H_GAP = 7'b0001000,
      H_READ = 7'b0010000,
      H_REL = 7'b0100000,
      H_TOKEN = 7'b1000000
   } phu_host_state_t;
   localparam int unsigned NSYNC = 10;
   localparam logic [31:0] SETTLE_LAST = 32'(PHU_SETTLE_CYC - 1);
   localparam logic [31:0] GAP_LAST = 32'(PHU_GAP_CYC - 1);
   localparam logic [31:0] STAB_LAST = 32'(STAB_CYC - 1);
   phu_host_state_t state_reg;
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] s1_reg;
   logic [NSYNC-1:0] s2_reg;
   logic [NSYNC-1:0] s3_reg;
   logic [NSYNC-1:0] pin_reg;
   logic [7:0] data_s;
   logic attn_s;
   logic rst_line_s;
   logic attn_q_reg;
   logic attn_seen_reg;
   logic tok_req_reg;
   logic [31:0] cnt_reg;
   logic first_reg;
   logic [7:0] remain_reg;
   logic a0_reg;
   logic cs_n_reg;
   logic rw_reg;
   logic [7:0] bus_d_reg;
   logic bus_oe_reg;
   logic rst_oe_reg;
   logic push_reg;
   logic [7:0] push_data_reg;
   logic busy_reg;
   logic dev_rst_reg;
   logic fifo_in_ready;
   logic attn_rise;
   logic settled;
   logic take_attn;
   logic take_tok;
   assign pin_raw = {link.host_reset_line, link.attention, link.data};
   assign data_s = pin_reg[7:0];
   assign attn_s = pin_reg[8];
   assign rst_line_s = pin_reg[9];
   assign attn_rise = attn_s & ~attn_q_reg;
   assign settled = (cnt_reg == SETTLE_LAST);
   assign take_attn = (state_reg == H_IDLE) & rst_line_s & attn_seen_reg &
                      ~tok_req_reg;
   assign take_tok = (state_reg == H_IDLE) & rst_line_s & tok_req_reg;
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            s1_reg[i] <= 1'b0;
            s2_reg[i] <= 1'b0;
            s3_reg[i] <= 1'b0;
            pin_reg[i] <= 1'b0;
         end else if (ce) begin
            s1_reg[i] <= pin_raw[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
            if (s2_reg[i] == s3_reg[i]) begin
               pin_reg[i] <= s3_reg[i];
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Attention edge and token request, sticky until taken
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         attn_q_reg <= 1'b0;
         attn_seen_reg <= 1'b0;
         tok_req_reg <= 1'b0;
      end else if (ce) begin
         attn_q_reg <= attn_s;
         if (attn_rise && state_reg != H_RST) begin
            attn_seen_reg <= 1'b1; // see RL16
         end else if (take_attn) begin
            attn_seen_reg <= 1'b0;
         end
         if (token_req) begin
            tok_req_reg <= 1'b1;
         end else if (take_tok) begin
            tok_req_reg <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg <= H_RST;
         cnt_reg <= '0;
         first_reg <= 1'b0;
         remain_reg <= PHU_ZERO_BYTE;
         push_reg <= 1'b0;
         push_data_reg <= PHU_ZERO_BYTE;
      end else if (ce) begin
         push_reg <= 1'b0;
         if (state_reg != H_RST && !rst_line_s) begin
            state_reg <= H_IDLE;
            cnt_reg <= '0;
         end else begin
            unique case (state_reg)
               H_RST: begin
                  if (cnt_reg == STAB_LAST) begin
                     cnt_reg <= '0;
                     state_reg <= H_IDLE; // see RL3
                  end else begin
                     cnt_reg <= cnt_reg + 1'b1;
                  end
               end
               H_IDLE: begin
                  cnt_reg <= '0;
                  if (take_tok) begin
                     state_reg <= H_TOKEN; // see RL6
                  end else if (take_attn) begin
                     first_reg <= 1'b1; // see RL9
                     state_reg <= H_POLL; // see RL16
                  end
               end
               H_POLL: begin
                  if (!settled) begin
                     cnt_reg <= cnt_reg + 1'b1;
                  end else if (data_s[PHU_HS_BIT]) begin
                     cnt_reg <= '0;
                     state_reg <= H_GAP; // see RL7
                  end
               end
               H_GAP: begin
                  if (cnt_reg == GAP_LAST) begin
                     cnt_reg <= '0;
                     state_reg <= H_READ;
                  end else begin
                     cnt_reg <= cnt_reg + 1'b1;
                  end
               end
               H_READ: begin
                  if (!settled) begin
                     cnt_reg <= cnt_reg + 1'b1;
                  end else begin
                     cnt_reg <= '0;
                     state_reg <= H_REL;
                     if (first_reg) begin
                        first_reg <= 1'b0;
                        remain_reg <= data_s; // see RL9
                     end else begin
                        push_reg <= 1'b1; // see RL7
                        push_data_reg <= data_s;
                        remain_reg <= remain_reg - 1'b1;
                     end
                  end
               end
               H_REL: begin
                  if (!settled) begin
                     cnt_reg <= cnt_reg + 1'b1;
                  end else if (remain_reg == PHU_ZERO_BYTE) begin
                     cnt_reg <= '0;
                     state_reg <= H_IDLE;
                  end else if (fifo_in_ready) begin
                     cnt_reg <= '0;
                     state_reg <= H_POLL; // see RL8
                  end
               end
               H_TOKEN: begin
                  if (!settled) begin
                     cnt_reg <= cnt_reg + 1'b1;
                  end else begin
                     cnt_reg <= '0;
                     state_reg <= H_REL;
                     remain_reg <= PHU_ZERO_BYTE;
                  end
               end
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Pin bridge: select line and data lines driven together
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         a0_reg <= PHU_SEL_DATA;
         cs_n_reg <= PHU_CS_OFF;
         rw_reg <= PHU_RW_READ;
         bus_d_reg <= PHU_NULL_TOKEN;
         bus_oe_reg <= 1'b0;
      end else if (ce) begin
         a0_reg <= (state_reg == H_POLL) ? PHU_SEL_HS : PHU_SEL_DATA; // see RL5 RL10
         cs_n_reg <= (state_reg == H_POLL || state_reg == H_READ ||
                      state_reg == H_TOKEN) ? PHU_CS_ON : PHU_CS_OFF; // see RL7
         rw_reg <= (state_reg == H_TOKEN) ? PHU_RW_WRITE : PHU_RW_READ; // see RL15
         bus_d_reg <= PHU_NULL_TOKEN;
         bus_oe_reg <= (state_reg == H_TOKEN); // see RL10
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Reset line and status
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rst_oe_reg <= 1'b1;
         busy_reg <= 1'b0;
         dev_rst_reg <= 1'b1;
      end else if (ce) begin
         rst_oe_reg <= (state_reg == H_RST) &&
                       (cnt_reg != STAB_LAST); // see RL3
         busy_reg <= (state_reg != H_IDLE) && (state_reg != H_RST);
         dev_rst_reg <= ~rst_line_s;
      end
   end
   phu_fifo #(
      .WIDTH(PHU_DATA_W),
      .DEPTH(PHU_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(push_reg),
      .in_ready(fifo_in_ready),
      .in_data(push_data_reg),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data)
   );
   assign link.handshake_select = a0_reg;
   assign link.chip_select_n = cs_n_reg;
   assign link.read_write = rw_reg;
   assign link.host_data = bus_d_reg;
   assign link.host_data_oe = bus_oe_reg;
   assign link.host_reset_oe = rst_oe_reg;
   assign rx_busy = busy_reg;
   assign dev_in_reset = dev_rst_reg;
endmodule : phu_host

// ===== sim/phu_link_sva.sv
`timescale 1ns/1ns
module phu_link_sva
   import phu_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic handshake_select,
   input wire logic chip_select_n,
   input wire logic read_write,
   input wire logic [7:0] host_data,
   input wire logic host_data_oe,
   input wire logic dev_data_oe,
   input wire logic [7:0] data,
   input wire logic attention,
   input wire logic dev_reset_oe
);
   logic [8:0] cnt_reg;
   logic hs_reg;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_gap;
      $fell(handshake_select) ##0 chip_select_n [*3];
   endsequence
   sequence s_read_go;
      $fell(chip_select_n) && !handshake_select && read_write;
   endsequence
   ////////////////////////////////////////
   // Reset pulse length
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !dev_reset_oe) begin
         cnt_reg <= 9'h000;
      end else begin
         cnt_reg <= cnt_reg + 9'h001;
      end
   end
   // Ready seen since last read
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !(chip_select_n || handshake_select)) begin
         hs_reg <= 1'b0;
      end else if (!chip_select_n && dev_data_oe && data[PHU_HS_BIT]) begin
         hs_reg <= 1'b1;
      end
   end
   ////////////////////////////////////////
   a_poll_read_level: assert property (
      !chip_select_n && handshake_select |-> read_write == PHU_RW_READ)
      else $error("write level in poll");
   a_poll_before_read: assert property (
      s_read_go |-> hs_reg) else $error("read without ready");
   a_gap_then_read: assert property (
      s_gap |-> ##[1:6] !chip_select_n && !handshake_select)
      else $error("no read after poll");
   a_host_drive_token: assert property (
      host_data_oe |-> host_data == PHU_NULL_TOKEN &&
      (chip_select_n || read_write == PHU_RW_WRITE)) else $error("bad write");
   a_one_bus_driver: assert property (
      !(host_data_oe && dev_data_oe)) else $error("bus contention");
   a_reset_pulse_len: assert property (
      $fell(dev_reset_oe) |-> cnt_reg == 9'h100) else $error("bad pulse");
   a_attn_low_gap: assert property (
      $fell(attention) |=> !attention) else $error("attention glitch");
   a_no_attn_write: assert property (
      !chip_select_n && read_write == PHU_RW_WRITE &&
      $past(chip_select_n, 5) == PHU_CS_ON |-> !$rose(attention))
      else $error("attention in write");
endmodule : phu_link_sva

// ===== sim/parallel_host_uplink_port_tb.sv
`timescale 1ns/1ns
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
   n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end
`define WAIT(c) for (n = 0; n < 3000 && (c); n++) @(negedge clk_sys)
module parallel_host_uplink_port_tb;
   import phu_pkg::*;
   logic clk_sys = 1'b0, rst_n = 1'b0, token_req = 1'b0, rx_ready = 1'b0;
   logic up_send = 1'b0, tx_valid = 1'b0, wdog_expire = 1'b0;
   logic soft_reset = 1'b0, stall = 1'b0, saw = 1'b0;
   logic [7:0] up_len = 8'h00, tx_data = 8'h00, rnd = 8'h3d;
   logic rx_valid, tx_ready, rx_busy, dev_in_reset, up_busy, token_held;
   logic [7:0] rx_data;
   logic [7:0] exp_q[$];
   int n_mismatch = 0, num_checks = 0, n_cyc = 0, n, len;
   int lens[4] = '{1, 0, 16, 5};
   phu_link_if link ();
   phu_host #(.STAB_CYC(20)) phu_host_inst (.clk_sys, .rst_n, .ce(1'b1),
      .link, .token_req, .rx_valid, .rx_ready, .rx_data, .rx_busy,
      .dev_in_reset);
   phu_device phu_device_inst (.clk_sys, .rst_n, .ce(1'b1), .link,
      .up_send, .up_len, .tx_valid, .tx_ready, .tx_data, .wdog_expire,
      .soft_reset, .up_busy, .token_held);
   phu_link_sva phu_link_sva_inst (.clk_sys, .rst_n,
      .handshake_select(link.handshake_select),
      .chip_select_n(link.chip_select_n), .read_write(link.read_write),
      .host_data(link.host_data), .host_data_oe(link.host_data_oe),
      .dev_data_oe(link.dev_data_oe), .data(link.data),
      .attention(link.attention), .dev_reset_oe(link.dev_reset_oe));
   ////////////////////////////////////////
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   always #25 clk_sys = ~clk_sys;
   always @(negedge clk_sys) begin
      rnd <= lfsr(rnd);
      rx_ready <= !stall && rnd[1];
   end
   always @(posedge clk_sys) begin
      n_cyc++;
      if (n_cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
      if (rx_valid === 1'b1 && rx_ready) begin
         `CHK(exp_q.size() > 0, 1'b1, "extra byte")
         `CHK(rx_data, exp_q.pop_front(), "rx byte")
      end
   end
   ////////////////////////////////////////
   initial begin
      repeat (10) @(negedge clk_sys);
      `CHK(link.host_reset_line, 1'b0, "reset held")
      rst_n = 1'b1;
      repeat (5) @(negedge clk_sys);
      `WAIT(dev_in_reset !== 1'b0);
      `CHK(n >= 15, 1'b1, "stable wait")
      repeat (8) @(negedge clk_sys);
      // Messages, fixed corners then random lengths
      for (int t = 0; t < 8; t++) begin
         len = t < 4 ? lens[t] : int'(rnd[3:0]);
         stall = (len == 16);
         saw = 1'b0;
         for (int i = 0; i < len; i++) begin
            tx_valid = 1'b1;
            tx_data = rnd;
            exp_q.push_back(rnd);
            while (tx_ready !== 1'b1) @(negedge clk_sys);
            @(negedge clk_sys);
         end
         tx_valid = 1'b0;
         if (len == 16) `CHK(tx_ready, 1'b0, "tx full")
         up_len = 8'(len);
         up_send = 1'b1;
         @(negedge clk_sys);
         up_send = 1'b0;
         @(negedge clk_sys);
         for (n = 0; n < 3000 && (up_busy !== 1'b0 || rx_busy !== 1'b0 ||
              (!stall && exp_q.size() > 0)); n++) begin
            saw |= link.attention;
            @(negedge clk_sys);
         end
         `CHK(saw, 1'b1, "no attention")
         if (stall) `CHK(rx_valid, 1'b1, "rx full")
         stall = 1'b0;
         repeat (80) @(negedge clk_sys);
         `CHK(exp_q.size(), 0, "bytes lost")
         $display("test %0d done", t);
      end
      // Null token pass
      token_req = 1'b1;
      @(negedge clk_sys);
      token_req = 1'b0;
      repeat (2) @(negedge clk_sys);
      saw = 1'b0;
      for (n = 0; n < 3000 && rx_busy !== 1'b0; n++) begin
         saw |= token_held;
         @(negedge clk_sys);
      end
      `CHK(saw, 1'b1, "no token pass")
      `CHK(token_held, 1'b0, "token kept")
      $display("test token done");
      // Watchdog then soft reset
      for (int k = 0; k < 2; k++) begin
         wdog_expire = (k == 0);
         soft_reset = (k == 1);
         @(negedge clk_sys);
         wdog_expire = 1'b0;
         soft_reset = 1'b0;
         `WAIT(dev_in_reset !== 1'b1);
         `WAIT(dev_in_reset !== 1'b0);
         `CHK(n > 250 && n < 262, 1'b1, "pulse length")
         $display("test reset %0d done", k);
      end
      end_sim();
   end
endmodule : parallel_host_uplink_port_tb
